// ---- mpi_device.sv ----
// device end of the parallel host port
`timescale 1ns/1ps
`default_nettype none
module mpi_device
    import mpi_pkg::*;
#(
    parameter int NUM_IRQ = 1
)
(
    input  wire logic                clock_i,
    input  wire logic                nrst_i,
    input  wire bus_mode_type        bus_mode_i,
    input  wire strobe_mode_type     strobe_mode_i,
    input  wire logic [NUM_IRQ-1:0]  irq_src_i,
    input  wire logic [DATA_W-1:0]   rd_data_i,
    output logic [ADDR_W-1:0]        reg_addr_o,
    output logic [DATA_W-1:0]        wr_data_o,
    output logic                     wr_stb_o,
    output logic                     rd_stb_o,
    output logic                     in_reset_o,
    mpi_if.device                    port
);
    typedef struct packed
    {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic              wr;
        logic              rd;
        logic              rd_act;
        logic              strobe_q;
        logic              wstb_q;
        logic              drive;
        logic              irq;
        bus_mode_type      bmode;
        strobe_mode_type   smode;
    } state_type;

    state_type state;
    state_type next_state;
    logic      dev_rst;
    logic      sel_rd;
    logic      sel_wr;
    logic      ds_rise;
    logic      wr_rise;
    logic      rd_start;
    logic      wr_end;

    // a low-active strobe that counts only while the chip select is low
    function automatic logic strobe_on(input logic sel_n, input logic stb_n);
        strobe_on = ~sel_n & ~stb_n;
    endfunction : strobe_on

    // release edge of a low-active strobe, against the level held one clock back
    function automatic logic strobe_release(input logic stb_n, input logic last_n);
        strobe_release = stb_n & ~last_n;
    endfunction : strobe_release

    // reset when host drives reset high or local reset low; the host keeps the reset
    // level for its minimum length, so a single high sample is taken as a reset
    assign dev_rst = port.rst | ~nrst_i;

    // decode strobes under the latched convention
    always_comb
    begin
        sel_rd  = 1'b0;
        sel_wr  = 1'b0;
        ds_rise = 1'b0;
        wr_rise = 1'b0;
        if (state.smode == STROBE_DIR_DS)
        begin
            // one strobe times both directions, the level says which
            sel_rd  = strobe_on(port.cs_n, port.data_strobe_n) & port.rw_wr_n;
            sel_wr  = strobe_on(port.cs_n, port.data_strobe_n) & ~port.rw_wr_n;
            ds_rise = strobe_release(port.data_strobe_n, state.strobe_q);
        end
        else
        begin
            // separate strobes, each names its own direction
            sel_rd  = strobe_on(port.cs_n, port.data_strobe_n);
            sel_wr  = strobe_on(port.cs_n, port.rw_wr_n);
            wr_rise = strobe_release(port.rw_wr_n, state.wstb_q);
        end
    end

    // first cycle of a read strobe, so a read fetches only once per access
    assign rd_start = sel_rd & ~state.rd_act;

    // a write ends at the release of its strobe while the chip is still selected;
    // committing at the end lets data that settles late in the strobe still land
    assign wr_end = ~port.cs_n & ((ds_rise & ~port.rw_wr_n) | wr_rise);

    // next-state logic
    always_comb
    begin
        next_state          = state;
        next_state.wr       = 1'b0;
        next_state.rd       = 1'b0;
        next_state.strobe_q = port.data_strobe_n;
        next_state.wstb_q   = port.rw_wr_n;
        // any source asks for attention; the line follows the sources one clock later
        next_state.irq      = |irq_src_i;
        // modes only taken while the chip select is high, the address phase of a muxed access included, so a mode pin
        // that moves while the chip is selected cannot turn a read into a write
        if (port.cs_n)
        begin
            next_state.bmode = bus_mode_i;
            next_state.smode = strobe_mode_i;
        end
        // address phase: muxed mode latches the low bus lines under the latch enable,
        // non-muxed mode follows the address inputs on every clock
        if (state.bmode == BUS_MUX)
        begin
            if (port.ale)
            begin
                next_state.addr = port.bus_line[ADDR_W-1:0];
            end
        end
        else
        begin
            next_state.addr = port.addr_in;
        end
        // write data tracked while strobe active, committed at its end
        if (sel_wr)
        begin
            next_state.wdata = port.bus_line;
        end
        if (wr_end)
        begin
            next_state.wr = 1'b1;
        end
        // read: fetch once at strobe start, hold until strobe ends; the register data is taken
        // in the same cycle as the fetch pulse, so it stands on the bus while the strobe is low
        // and the host finds it before it lets the strobe go
        if (rd_start)
        begin
            next_state.rd     = 1'b1;
            next_state.rd_act = 1'b1;
            next_state.rdata  = rd_data_i;
        end
        if (~sel_rd)
        begin
            next_state.rd_act = 1'b0;
        end
        // a read in the address phase never drives, the host owns the lines then
        next_state.drive = sel_rd & ~port.ale;
        // strobe history resets to the idle high level, so no false release follows reset
        if (dev_rst)
        begin
            next_state        = '0;
            next_state.strobe_q = 1'b1;
            next_state.wstb_q   = 1'b1;
        end
    end

    // state register
    always_ff @(posedge clock_i)
    begin
        state <= next_state;
    end

    // register side: address, write data and one-cycle strobes from flip-flops, the reset flag straight from dev_rst
    assign reg_addr_o      = state.addr;
    assign wr_data_o       = state.wdata;
    assign wr_stb_o        = state.wr;
    assign rd_stb_o        = state.rd;
    assign in_reset_o      = dev_rst;

    // pin side: the bus is only driven in the data phase of a selected read, and shows a
    // fixed idle word otherwise so nothing stale leaks out while the host owns the lines
    assign port.dev_bus_o  = state.drive ? state.rdata : IDLE_DATA;
    assign port.dev_bus_oe = state.drive;

    // request line: the enable pulls it low, released otherwise, so several ends can share it
    assign port.irq_n_oe   = state.irq;
endmodule : mpi_device
`default_nettype wire

// ---- mpi_pkg.sv ----
// shared constants and types for the parallel host port
package mpi_pkg;
    localparam int          DATA_W        = 8;
    localparam int          ADDR_W        = 6;
    localparam int          RESET_MIN_CYC = 4;
    localparam logic [7:0]  IDLE_DATA     = 8'h00;

    // bus wiring: multiplexed address/data or separate address inputs
    typedef enum logic [0:0]
    {
        BUS_NONMUX = 1'b0,
        BUS_MUX    = 1'b1
    } bus_mode_type;

    // strobe convention: direction level plus data strobe, or separate read and write strobes
    typedef enum logic [0:0]
    {
        STROBE_DIR_DS = 1'b0,
        STROBE_RD_WR  = 1'b1
    } strobe_mode_type;
endpackage : mpi_pkg

// ---- mpi_if.sv ----
// pin-level carrier between host and device
`timescale 1ns/1ps
`default_nettype none
interface mpi_if;
    import mpi_pkg::*;
    logic [DATA_W-1:0] host_bus_o;
    logic              host_bus_oe;
    logic [DATA_W-1:0] dev_bus_o;
    logic              dev_bus_oe;
    logic [DATA_W-1:0] bus_line;
    logic [ADDR_W-1:0] addr_in;
    logic              cs_n;
    logic              rw_wr_n;
    logic              data_strobe_n;
    logic              ale;
    logic              irq_n_oe;
    logic              irq_n;
    logic              rst;

    // wire resolution: host driver wins over device, idle bus floats high
    assign bus_line = host_bus_oe ? host_bus_o : (dev_bus_oe ? dev_bus_o : {DATA_W{1'b1}});
    assign irq_n    = ~irq_n_oe;

    modport host
    (
        output host_bus_o, host_bus_oe, addr_in, cs_n, rw_wr_n, data_strobe_n, ale, rst,
        input  bus_line, irq_n
    );
    modport device
    (
        output dev_bus_o, dev_bus_oe, irq_n_oe,
        input  bus_line, addr_in, cs_n, rw_wr_n, data_strobe_n, ale, rst
    );
endinterface : mpi_if
`default_nettype wire

// ---- mpi_host.sv ----
// host end of the parallel host port
`timescale 1ns/1ps
`default_nettype none
module mpi_host
    import mpi_pkg::*;
(
    input  wire logic                clock_i,
    input  wire logic                nrst_i,
    input  wire bus_mode_type        bus_mode_i,
    input  wire strobe_mode_type     strobe_mode_i,
    input  wire logic                req_i,
    input  wire logic                req_wr_i,
    input  wire logic [ADDR_W-1:0]   req_addr_i,
    input  wire logic [DATA_W-1:0]   req_data_i,
    input  wire logic                dev_reset_i,
    output logic                     busy_o,
    output logic                     done_o,
    output logic [DATA_W-1:0]        rd_data_o,
    output logic                     irq_o,
    mpi_if.host                      port
);
    typedef enum logic [2:0]
    {
        ST_IDLE  = 3'b000,
        ST_ALE   = 3'b001,
        ST_SETUP = 3'b010,
        ST_STB1  = 3'b011,
        ST_STB2  = 3'b100,
        ST_END   = 3'b101
    } phase_type;

    typedef struct packed
    {
        phase_type         phase;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [DATA_W-1:0] rdata;
        logic              done;
        logic [2:0]        rst_cnt;
    } state_type;

    state_type state;
    state_type next_state;
    logic      active;
    logic      strobe;

    assign active = (state.phase != ST_IDLE);
    assign strobe = (state.phase == ST_STB1) | (state.phase == ST_STB2);

    // sequence one access
    always_comb
    begin
        next_state      = state;
        next_state.done = 1'b0;
        if (state.rst_cnt != 3'h0)
        begin
            next_state.rst_cnt = state.rst_cnt - 3'h1;
        end
        unique case (state.phase)
            ST_IDLE:
            begin
                if (dev_reset_i)
                begin
                    next_state.rst_cnt = 3'(RESET_MIN_CYC);
                end
                else if (req_i & (state.rst_cnt == 3'h0))
                begin
                    next_state.wr    = req_wr_i;
                    next_state.addr  = req_addr_i;
                    next_state.data  = req_data_i;
                    next_state.phase = (bus_mode_i == BUS_MUX) ? ST_ALE : ST_SETUP;
                end
            end
            ST_ALE:   next_state.phase = ST_SETUP;
            ST_SETUP: next_state.phase = ST_STB1;
            ST_STB1:  next_state.phase = ST_STB2;
            ST_STB2:
            begin
                next_state.phase = ST_END;
                // read data taken while the strobe is still low; a write leaves it alone
                if (~state.wr)
                begin
                    next_state.rdata = port.bus_line;
                end
            end
            ST_END:
            begin
                next_state.phase = ST_IDLE;
                next_state.done  = 1'b1;
            end
            default:  next_state.phase = ST_IDLE;
        endcase
        if (~nrst_i)
        begin
            next_state = '0;
        end
    end

    // state register
    always_ff @(posedge clock_i)
    begin
        state <= next_state;
    end

    // pin drive per strobe convention
    always_comb
    begin
        port.cs_n          = ~(active & (state.phase != ST_ALE));
        port.ale           = (state.phase == ST_ALE);
        port.addr_in       = state.addr;
        port.host_bus_o    = port.ale ? {{(DATA_W-ADDR_W){1'b0}}, state.addr} : state.data;
        port.host_bus_oe   = port.ale | (active & state.wr);
        port.rst           = (state.rst_cnt != 3'h0);
        if (strobe_mode_i == STROBE_DIR_DS)
        begin
            port.rw_wr_n       = ~state.wr;
            port.data_strobe_n = ~strobe;
        end
        else
        begin
            port.rw_wr_n       = ~(strobe & state.wr);
            port.data_strobe_n = ~(strobe & ~state.wr);
        end
    end

    assign busy_o    = active | port.rst;
    assign done_o    = state.done;
    assign rd_data_o = state.rdata;
    assign irq_o     = ~port.irq_n;
endmodule : mpi_host
`default_nettype wire

// ---- mpi_checker.sv ----
// concurrent checks on the host port wires
`timescale 1ns/1ps
`default_nettype none
module mpi_checker
(
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic host_bus_oe,
    input wire logic dev_bus_oe,
    input wire logic cs_n,
    input wire logic rw_wr_n,
    input wire logic data_strobe_n,
    input wire logic ale,
    input wire logic irq_n_oe,
    input wire logic rst
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    // a selected read strobe starts, and the data strobe ends
    sequence read_start;
        $fell(data_strobe_n) && rw_wr_n && !cs_n;
    endsequence
    sequence strobe_end;
        $rose(data_strobe_n);
    endsequence
    a_no_contention: assert property (!(host_bus_oe && dev_bus_oe))
        else $error("both ends drive the bus");
    a_read_drive: assert property (read_start |-> ##[1:4] dev_bus_oe)
        else $error("read not answered on the bus");
    a_drive_release: assert property (strobe_end |-> ##[1:2] !dev_bus_oe)
        else $error("bus held after strobe end");
    a_no_write_drive: assert property (dev_bus_oe |-> rw_wr_n)
        else $error("device drives during write");
    a_strobe_select: assert property (!data_strobe_n |-> !cs_n)
        else $error("strobe without select");
    a_ale_address: assert property (ale |-> cs_n && host_bus_oe)
        else $error("address phase malformed");
    a_write_data: assert property (!cs_n && !rw_wr_n |-> host_bus_oe)
        else $error("write without host data");
    a_reset_length: assert property ($rose(rst) |-> rst [*4])
        else $error("reset pulse too short");
    a_reset_quiet: assert property (rst && $past(rst) |-> !dev_bus_oe && !irq_n_oe)
        else $error("device active in reset");
endmodule : mpi_checker
`default_nettype wire

// ---- tb_top.sv ----
// end to end bench for the host port pair
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import mpi_pkg::*;
    logic              clock_i = 0;
    logic              nrst_i = 0;
    bus_mode_type      bmode = BUS_NONMUX;
    strobe_mode_type   smode = STROBE_DIR_DS;
    logic              req_i = 0;
    logic              req_wr_i = 0;
    logic              dev_reset_i = 0;
    logic [ADDR_W-1:0] req_addr_i = '0;
    logic [ADDR_W-1:0] reg_addr_o;
    logic [DATA_W-1:0] req_data_i = '0;
    logic [DATA_W-1:0] rd_data_i = '0;
    logic [DATA_W-1:0] rd_data_o;
    logic [DATA_W-1:0] wr_data_o;
    logic [1:0]        irq_src_i = '0;
    logic              wr_stb_o;
    logic              rd_stb_o;
    logic              busy_o;
    int                n_rd = 0;
    int                exp_rd = 0;
    logic              in_reset_o;
    logic              done_o;
    logic              irq_o;
    logic [14:0]       exp_q[$];
    int                failures = 0;
    int                n_checks = 0;
    int                n_wr = 0;
    int                exp_wr = 0;
    int                seed = 19685;
    mpi_if port ();
    mpi_device #(.NUM_IRQ(2)) i_mpi_device (.clock_i(clock_i), .nrst_i(nrst_i), .bus_mode_i(bmode),
        .strobe_mode_i(smode), .irq_src_i(irq_src_i), .rd_data_i(rd_data_i), .reg_addr_o(reg_addr_o),
        .wr_data_o(wr_data_o), .wr_stb_o(wr_stb_o), .rd_stb_o(rd_stb_o), .in_reset_o(in_reset_o), .port(port));
    mpi_host i_mpi_host (.clock_i(clock_i), .nrst_i(nrst_i), .bus_mode_i(bmode), .strobe_mode_i(smode),
        .req_i(req_i), .req_wr_i(req_wr_i), .req_addr_i(req_addr_i), .req_data_i(req_data_i),
        .dev_reset_i(dev_reset_i), .busy_o(busy_o), .done_o(done_o), .rd_data_o(rd_data_o), .irq_o(irq_o),
        .port(port));
    mpi_checker i_mpi_checker (.clock_i(clock_i), .nrst_i(nrst_i), .host_bus_oe(port.host_bus_oe),
        .dev_bus_oe(port.dev_bus_oe), .cs_n(port.cs_n), .rw_wr_n(port.rw_wr_n),
        .data_strobe_n(port.data_strobe_n), .ale(port.ale), .irq_n_oe(port.irq_n_oe), .rst(port.rst));
    // free running clock
    always #5 clock_i = ~clock_i;
    task automatic chk(input string what, input logic [14:0] exp, input logic [14:0] seen);
        n_checks++;
        if (exp !== seen)
        begin
            failures++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop
    // one host access with random address and data, noted in the queue
    task automatic access(input logic rd);
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] d;
        a = ADDR_W'($random(seed));
        d = DATA_W'($random(seed));
        @(negedge clock_i);
        req_i = 1;
        req_wr_i = !rd;
        req_addr_i = a;
        req_data_i = d;
        if (rd)
        begin
            rd_data_i = d;
            exp_rd++;
        end
        else
            exp_wr++;
        exp_q.push_back({rd, a, d});
        @(negedge clock_i);
        req_i = 0;
        chk("busy", 15'h1, 15'(busy_o));
        for (int i = 0; i < 20 && done_o !== 1'b1; i++)
            @(negedge clock_i);
        chk("access done", 15'h1, 15'(done_o));
        @(negedge clock_i);
        chk("idle", 15'h0, 15'(busy_o));
    endtask : access
    // compare completed accesses with the oldest note, and the wire contents
    always @(negedge clock_i)
    begin
        logic [14:0] e;
        if (wr_stb_o === 1'b1)
            n_wr++;
        if (rd_stb_o === 1'b1)
            n_rd++;
        if (port.ale === 1'b1)
            chk("mux address", 15'(req_addr_i), 15'(port.bus_line[ADDR_W-1:0]));
        if (bmode == BUS_NONMUX && port.cs_n === 1'b0)
            chk("address inputs", 15'(req_addr_i), 15'(port.addr_in));
        if (done_o === 1'b1 && exp_q.size() > 0)
        begin
            e = exp_q.pop_front();
            chk("access", e, {e[14], reg_addr_o, e[14] ? rd_data_o : wr_data_o});
        end
    end
    // main sequence: all mode pairs, then interrupt and device reset
    initial
    begin
        repeat (2) @(negedge clock_i);
        nrst_i = 1;
        for (int m = 0; m < 4; m++)
        begin
            bmode = bus_mode_type'(m[0]);
            smode = strobe_mode_type'(m[1]);
            repeat (3)
            begin
                access(1'b0);
                access(1'b1);
                access(1'($random(seed)));
            end
            $display("test mode %0d done", m);
        end
        chk("writes", 15'(exp_wr), 15'(n_wr));
        chk("reads", 15'(exp_rd), 15'(n_rd));
        irq_src_i = 2'b10;
        repeat (3) @(negedge clock_i);
        chk("irq raised", 15'h3, {13'h0, irq_o, !port.irq_n});
        dev_reset_i = 1;
        @(negedge clock_i);
        dev_reset_i = 0;
        repeat (2) @(negedge clock_i);
        chk("in reset", 15'h7, {12'h0, in_reset_o, port.rst, port.irq_n});
        repeat (6) @(negedge clock_i);
        chk("reset over", 15'h1, {13'h0, in_reset_o, irq_o});
        irq_src_i = 2'b00;
        repeat (3) @(negedge clock_i);
        chk("irq released", 15'h1, {14'h0, port.irq_n});
        chk("queue empty", 15'h0, 15'(exp_q.size()));
        $display("test irq and reset done");
        report_and_stop();
    end
    // cut a hang short
    initial
    begin
        #100000;
        failures++;
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
